/* logic/rmc_pkg.sv */
// constants and types for the receive mode-command control word block
package rmc_pkg;
  localparam int          WORD_W        = 16;         // control word width
  localparam logic [4:0]  SA_MODE_LO    = 5'h00;      // mode subaddress zero
  localparam logic [4:0]  SA_MODE_HI    = 5'h1f;      // mode subaddress 31
  localparam logic [4:0]  RT_BCAST_ADDR = 5'h1f;      // broadcast terminal address
  localparam logic [4:0]  MC_DATA_LO    = 5'h10;      // first mode code carrying data
  localparam int          BIT_IXEQZ     = 15;         // index-zero irq enable (kept only)
  localparam int          BIT_IWA       = 14;         // irq on access enable
  localparam int          BIT_IBR       = 13;         // irq on broadcast rx enable
  localparam int          BIT_BUSY      = 12;         // force busy response
  localparam int          BIT_DESCRIPTOR_ACCESSED_FLAG      = 11;         // descriptor accessed flag
  localparam int          BIT_DPB       = 10;         // next buffer select
  localparam int          BIT_BCAST     = 9;          // broadcast received
  localparam int          BIT_PPON      = 8;          // ping-pong acknowledge
  localparam int          BIT_STOPP     = 3;          // stop ping-pong request
  localparam int          BIT_PINGPONG_SELECT      = 2;          // ping-pong select
  localparam logic [15:0] WORD_RESET    = 16'h0000;   // master reset value
  localparam logic [15:0] HOST_WR_ANY   = 16'hf008;   // bits writable any time
  localparam logic [15:0] HOST_WR_IDLE  = 16'h0004;   // bits writable when not executing
  typedef enum logic [2:0] {
    RMC_IDLE = 3'b001,                                // waiting for a command
    RMC_BUSY = 3'b010,                                // command in progress
    RMC_DONE = 3'b100                                 // completion bookkeeping
  } rmc_state_t;
endpackage : rmc_pkg

/* logic/rmc_cmd_decode.sv */
// decoder that qualifies a 1553 command word for the receive mode control word
module rmc_cmd_decode (
  input  wire logic [15:0] cmd_word,        // received command word
  input  wire logic [4:0]  own_addr,        // this terminal's address
  input  wire logic        bcast_disable,   // broadcast commands treated invalid
  output logic             is_rx_mode,      // receive mode command for us
  output logic             is_bcast,        // valid broadcast receive mode command
  output logic             has_data         // mode code 16..31 (carries a data word)
);
  logic [4:0] addr;                          // terminal address field
  logic [4:0] sub;                           // subaddress field
  logic       addr_ok;                       // addressed to us or valid broadcast
  always_comb begin
    addr = cmd_word[15:11];
    sub  = cmd_word[9:5];
    is_bcast = (addr == rmc_pkg::RT_BCAST_ADDR) && !bcast_disable;
    addr_ok = (addr == own_addr) || is_bcast;
    is_rx_mode = addr_ok && !cmd_word[10] &&
                 ((sub == rmc_pkg::SA_MODE_LO) || (sub == rmc_pkg::SA_MODE_HI));
    is_bcast = is_bcast && is_rx_mode;
    has_data = cmd_word[4:0] >= rmc_pkg::MC_DATA_LO;
  end
endmodule : rmc_cmd_decode

/* logic/rmc_ctrl_word.sv */
// receive mode-command descriptor control word with event, busy and ping-pong logic
// Function
// - apply word only to receive mode commands
// - access interrupt when both enables set and message error-free
// - broadcast interrupt when both enables set and message error-free
// - broadcast disable makes address 31 invalid
// - force busy answers this code busy
// - busy: no data store, no toggle
// - set accessed flag on message completion
// - accessed flag cleared by resets, reads
// - pointer picks buffer A or B
// - pointer inverts after error-free message
// - toggle hold keeps pointer on failures
// - resets clear the pointer
// - pointer ignored in indexed mode
module rmc_ctrl_word (
  input  wire logic        sys_clk,           // 50 MHz clock
  input  wire logic        sys_rst,           // sync reset, high
  input  wire logic        master_reset_pin,  // master reset, high, clears all
  input  wire logic        soft_reset_cmd,    // software reset pulse
  input  wire logic        host_rd,           // host read strobe of the word
  input  wire logic        host_wr,           // host write strobe of the word
  input  wire logic [15:0] host_wdata,        // host write data
  input  wire logic        exec_active,       // terminal executing
  input  wire logic        cmd_valid,         // pulse: new command word
  input  wire logic [15:0] cmd_word,          // command word
  input  wire logic [4:0]  own_addr,          // terminal address
  input  wire logic        msg_done,          // pulse: message processing complete
  input  wire logic        msg_error,         // with msg_done: illegal or failed
  input  wire logic        global_busy,       // global busy setting
  input  wire logic        gie_access,        // global access irq enable
  input  wire logic        gie_bcast,         // global broadcast irq enable
  input  wire logic        bcast_disable,     // broadcast commands invalid
  input  wire logic        buffer_toggle_hold,// keep pointer after failures
  output logic [15:0]      host_rdata,        // registered control word image
  output logic             busy_resp,         // busy bit for the status word
  output logic             use_buf_b,         // buffer B selected for message
  output logic             store_data_en,     // data word may be stored
  output logic             irq_access,        // pulse: access interrupt posted
  output logic             irq_bcast          // pulse: broadcast interrupt posted
);
  rmc_pkg::rmc_state_t state, next_state;     // message tracker
  logic [15:0] word, next_word;               // control word storage
  logic        bc_cmd, next_bc_cmd;           // latched broadcast flag
  logic        dat_cmd, next_dat_cmd;         // latched mode-code-with-data flag
  logic        next_busy_resp, next_use_buf_b, next_store_data_en;
  logic        next_irq_access, next_irq_bcast;
  logic        dec_rx, dec_bc, dec_data;      // decoder outputs
  logic        done_ev;                       // completion of our message

  rmc_cmd_decode u_dec (
    .cmd_word      (cmd_word),
    .own_addr      (own_addr),
    .bcast_disable (bcast_disable),
    .is_rx_mode    (dec_rx),
    .is_bcast      (dec_bc),
    .has_data      (dec_data)
  );

  // next-state and word update
  always_comb begin
    next_state = state;
    next_word = word;
    next_bc_cmd = bc_cmd;
    next_dat_cmd = dat_cmd;
    next_busy_resp = busy_resp;
    next_use_buf_b = use_buf_b;
    next_store_data_en = store_data_en;
    next_irq_access = 1'b0;
    next_irq_bcast = 1'b0;
    done_ev = 1'b0;
    // host writes: status bits 8-11 are never host writable
    if (host_wr) begin
      next_word = (word & ~rmc_pkg::HOST_WR_ANY) | (host_wdata & rmc_pkg::HOST_WR_ANY);
      if (!exec_active) begin
        next_word[rmc_pkg::BIT_PINGPONG_SELECT] = host_wdata[rmc_pkg::BIT_PINGPONG_SELECT];
      end
    end
    if (host_rd) begin
      next_word[rmc_pkg::BIT_DESCRIPTOR_ACCESSED_FLAG] = 1'b0;
    end
    // ping-pong ack follows select and stop request
    next_word[rmc_pkg::BIT_PPON] = word[rmc_pkg::BIT_PINGPONG_SELECT] && !word[rmc_pkg::BIT_STOPP];
    case (state)
      rmc_pkg::RMC_IDLE: begin
        if (cmd_valid && dec_rx) begin
          next_bc_cmd = dec_bc;
          next_dat_cmd = dec_data;
          next_busy_resp = global_busy || word[rmc_pkg::BIT_BUSY];
          next_use_buf_b = word[rmc_pkg::BIT_PINGPONG_SELECT] && word[rmc_pkg::BIT_DPB];
          next_store_data_en = dec_data && !(global_busy || word[rmc_pkg::BIT_BUSY]);
          next_state = rmc_pkg::RMC_BUSY;
        end
      end
      rmc_pkg::RMC_BUSY: begin
        if (msg_done) begin
          done_ev = 1'b1;
          next_state = rmc_pkg::RMC_DONE;
        end
      end
      rmc_pkg::RMC_DONE: begin
        next_busy_resp = 1'b0;
        next_store_data_en = 1'b0;
        next_state = rmc_pkg::RMC_IDLE;
      end
      default: begin
        next_state = rmc_pkg::RMC_IDLE;
      end
    endcase
    if (done_ev) begin
      // set accessed; set wins over read clear
      next_word[rmc_pkg::BIT_DESCRIPTOR_ACCESSED_FLAG] = 1'b1;
      if (bc_cmd) begin
        next_word[rmc_pkg::BIT_BCAST] = 1'b1;
      end
      next_irq_access = gie_access && word[rmc_pkg::BIT_IWA] && !msg_error;
      next_irq_bcast = gie_bcast && word[rmc_pkg::BIT_IBR] && bc_cmd && !msg_error;
      // toggle; not under busy; hold on failure
      if (word[rmc_pkg::BIT_PINGPONG_SELECT] && word[rmc_pkg::BIT_PPON] && !busy_resp &&
          !(msg_error && buffer_toggle_hold)) begin
        next_word[rmc_pkg::BIT_DPB] = !word[rmc_pkg::BIT_DPB];
      end
    end
    // soft reset clears accessed and broadcast flags; pointer too
    if (soft_reset_cmd) begin
      next_word[rmc_pkg::BIT_DESCRIPTOR_ACCESSED_FLAG] = 1'b0;
      next_word[rmc_pkg::BIT_DPB] = 1'b0;
      next_word[rmc_pkg::BIT_BCAST] = 1'b0;
    end
  end

  // registers; master reset clears whole word
  always_ff @(posedge sys_clk) begin
    if (sys_rst || master_reset_pin) begin
      state <= rmc_pkg::RMC_IDLE;
      word <= rmc_pkg::WORD_RESET;
      bc_cmd <= 1'b0;
      dat_cmd <= 1'b0;
      busy_resp <= 1'b0;
      use_buf_b <= 1'b0;
      store_data_en <= 1'b0;
      irq_access <= 1'b0;
      irq_bcast <= 1'b0;
      host_rdata <= rmc_pkg::WORD_RESET;
    end else begin
      state <= next_state;
      word <= next_word;
      bc_cmd <= next_bc_cmd;
      dat_cmd <= next_dat_cmd;
      busy_resp <= next_busy_resp;
      use_buf_b <= next_use_buf_b;
      store_data_en <= next_store_data_en;
      irq_access <= next_irq_access;
      irq_bcast <= next_irq_bcast;
      host_rdata <= next_word;
    end
  end

  // checks
  property p_descriptor_accessed_flag_set;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_BUSY && msg_done && !soft_reset_cmd) |=> word[rmc_pkg::BIT_DESCRIPTOR_ACCESSED_FLAG];
  endproperty
  a_descriptor_accessed_flag_set: assert property (p_descriptor_accessed_flag_set) else $error("accessed flag not set");
  property p_descriptor_accessed_flag_rdclr;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (host_rd && !(state == rmc_pkg::RMC_BUSY && msg_done)) |=> !word[rmc_pkg::BIT_DESCRIPTOR_ACCESSED_FLAG];
  endproperty
  a_descriptor_accessed_flag_rdclr: assert property (p_descriptor_accessed_flag_rdclr) else $error("read did not clear flag");
  property p_soft_reset_cmd;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      soft_reset_cmd |=> !word[rmc_pkg::BIT_DPB] && !word[rmc_pkg::BIT_BCAST];
  endproperty
  a_soft_reset_cmd: assert property (p_soft_reset_cmd) else $error("soft reset left status");
  property p_busy;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_IDLE && cmd_valid && dec_rx && word[rmc_pkg::BIT_BUSY]) |=> busy_resp && !store_data_en;
  endproperty
  a_busy: assert property (p_busy) else $error("force busy ignored");
  property p_no_toggle_busy;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_BUSY && msg_done && busy_resp && !soft_reset_cmd) |=> $stable(word[rmc_pkg::BIT_DPB]);
  endproperty
  a_no_toggle_busy: assert property (p_no_toggle_busy) else $error("pointer toggled under busy");
  property p_toggle;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_BUSY && msg_done && !msg_error && !busy_resp && !soft_reset_cmd &&
       word[rmc_pkg::BIT_PINGPONG_SELECT] && word[rmc_pkg::BIT_PPON]) |=> word[rmc_pkg::BIT_DPB] != $past(word[rmc_pkg::BIT_DPB]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pointer not inverted");
  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_BUSY && msg_done && msg_error && buffer_toggle_hold && !soft_reset_cmd) |=>
        $stable(word[rmc_pkg::BIT_DPB]);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved on failure");
  property p_irq;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_BUSY && msg_done && !msg_error && gie_access && word[rmc_pkg::BIT_IWA]) |=> irq_access;
  endproperty
  a_irq: assert property (p_irq) else $error("access irq missing");
  property p_irqb;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      irq_bcast |-> $past(bc_cmd) && $past(word[rmc_pkg::BIT_IBR]) && $past(gie_bcast);
  endproperty
  a_irqb: assert property (p_irqb) else $error("bad broadcast irq");
  property p_bufsel;
    @(posedge sys_clk) disable iff (sys_rst || master_reset_pin)
      (state == rmc_pkg::RMC_IDLE && cmd_valid && dec_rx) |=> use_buf_b == ($past(word[rmc_pkg::BIT_PINGPONG_SELECT]) && $past(word[rmc_pkg::BIT_DPB]));
  endproperty
  a_bufsel: assert property (p_bufsel) else $error("wrong buffer");
  c_msg: cover property (@(posedge sys_clk) disable iff (sys_rst) state == rmc_pkg::RMC_BUSY ##[1:50] msg_done);
  c_irq: cover property (@(posedge sys_clk) disable iff (sys_rst) irq_access);
  c_bc: cover property (@(posedge sys_clk) disable iff (sys_rst) irq_bcast);
endmodule : rmc_ctrl_word

/* tb/rmc_bc_model.sv */
// bus controller model issuing receive mode commands and completions
module rmc_bc_model (
  input  wire logic        sys_clk,       // block clock
  input  wire logic        busy_resp,     // busy answered
  input  wire logic        use_buf_b,     // buffer b chosen
  input  wire logic        store_data_en, // data store allowed
  input  wire logic        irq_access,    // access irq pulse
  input  wire logic        irq_bcast,     // broadcast irq pulse
  output logic             cmd_valid,     // command strobe
  output logic [15:0]      cmd_word,      // command word
  output logic             msg_done,      // completion strobe
  output logic             msg_error      // completion failed
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = 16'h0000;
    msg_done  = 1'b0;
    msg_error = 1'b0;
  end
  // one message; a negative gap sends the command alone, slow gaps model a slow bus
  task automatic send(input logic [15:0] w, input logic err, input int gap,
                      output logic [2:0] resp, output logic [1:0] irq);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_word  = w;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // released word flips so a stale value never looks valid
    cmd_word  = ~w;
    resp      = {busy_resp, use_buf_b, store_data_en};
    irq       = 2'b00;
    if (gap >= 0) begin
      repeat (gap) @(negedge sys_clk);
      msg_done  = 1'b1;
      msg_error = err;
      @(negedge sys_clk);
      msg_done  = 1'b0;
      msg_error = ~err;
      irq       = {irq_access, irq_bcast};
    end
    repeat (2) @(negedge sys_clk);
  endtask : send
endmodule : rmc_bc_model

/* tb/rt_rx_mode_ctrl_word_test.sv */
// self-checking bench for the receive mode control word block
module rt_rx_mode_ctrl_word_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, sys_rst, master_reset_pin, soft_reset_cmd, host_rd, host_wr, exec_active;
  logic        global_busy, gie_access, gie_bcast, bcast_disable, buffer_toggle_hold;
  logic [15:0] host_wdata, host_rdata, cmd_word, cmd, ctl;  // host and command words
  logic [4:0]  own_addr, exp;                                // address, predicted outcome
  logic        busy_resp, use_buf_b, store_data_en, irq_access, irq_bcast, cmd_valid, msg_done, msg_error;
  logic        next_buffer_select, err;                                     // modelled pointer, error pick
  logic [2:0]  resp;                                         // sampled message outputs
  logic [1:0]  irq;                                          // sampled irq pulses
  int          errors = 0, check_count = 0, seed = 10590, gap;
  rmc_ctrl_word rmc_ctrl_word_inst (.sys_clk, .sys_rst, .master_reset_pin, .soft_reset_cmd, .host_rd,
    .host_wr, .host_wdata, .exec_active, .cmd_valid, .cmd_word, .own_addr, .msg_done, .msg_error,
    .global_busy, .gie_access, .gie_bcast, .bcast_disable, .buffer_toggle_hold, .host_rdata,
    .busy_resp, .use_buf_b, .store_data_en, .irq_access, .irq_bcast);
  rmc_bc_model rmc_bc_model_inst (.sys_clk, .busy_resp, .use_buf_b, .store_data_en, .irq_access,
    .irq_bcast, .cmd_valid, .cmd_word, .msg_done, .msg_error);
  always #10 sys_clk = ~sys_clk;
  // counted compare, x matches only x
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  // one host write cycle, then a cycle for the acknowledge bit to follow
  task automatic wr(input logic [15:0] d);
    @(negedge sys_clk);
    host_wr    = 1'b1;
    host_wdata = d;
    @(negedge sys_clk);
    host_wr    = 1'b0;
    @(negedge sys_clk);
  endtask : wr
  // one-cycle strobe: read when sel set, soft reset otherwise
  task automatic pulse(input logic sel);
    @(negedge sys_clk);
    host_rd        = sel;
    soft_reset_cmd = ~sel;
    @(negedge sys_clk);
    host_rd        = 1'b0;
    soft_reset_cmd = 1'b0;
  endtask : pulse
  // predicted {busy, store, irq access, irq broadcast, toggle} for one message
  function automatic logic [4:0] predict(input logic [15:0] c, input logic [15:0] w, input logic e);
    logic busy;
    busy = w[12] | global_busy;
    return {busy, ~busy & (c[4:0] >= 5'h10), ~e & gie_access & w[14],
            ~e & gie_bcast & w[13] & (c[15:11] == 5'h1f), ~busy & (~e | ~buffer_toggle_hold)};
  endfunction : predict
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // watchdog cuts a hang well past the expected run length
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
  initial begin
    {sys_clk, master_reset_pin, soft_reset_cmd, host_rd, host_wr, exec_active, global_busy} = '0;
    {gie_access, gie_bcast, bcast_disable, buffer_toggle_hold, host_wdata, next_buffer_select} = '0;
    sys_rst  = 1'b1;
    own_addr = 5'h05;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(host_rdata, 16'h0000);
    wr(16'h0004);
    chk(host_rdata, 16'h0104);
    exec_active = 1'b1;
    wr(16'h0f08);
    chk(host_rdata, 16'h000c);
    repeat (40) begin
      ctl = {1'b0, 2'($random(seed)), 1'($random(seed)), 12'h004};
      cmd = {($random(seed) % 3 == 0) ? 5'h1f : 5'h05, 1'b0, 1'($random(seed)) ? 5'h1f : 5'h00, 5'($random(seed))};
      {global_busy, gie_access, gie_bcast, err} = 4'($random(seed));
      buffer_toggle_hold = 1'($random(seed));
      gap = $random(seed) & 3;
      wr(ctl);
      exp = predict(cmd, ctl, err);
      rmc_bc_model_inst.send(cmd, err, gap, resp, irq);
      chk({13'h0, resp}, {13'h0, exp[4], next_buffer_select, exp[3]});
      chk({14'h0, irq}, {14'h0, exp[2:1]});
      next_buffer_select ^= exp[0];
      chk(host_rdata & 16'hfdff, {ctl[15:12], 1'b1, next_buffer_select, 2'b01, 8'h04});
      pulse(1'b1);
      chk({15'h0, host_rdata[11]}, 16'h0000);
    end
    // transmit command and disabled broadcast are both refused; global busy makes a wrong take visible
    bcast_disable = 1'b1;
    global_busy   = 1'b1;
    for (int i = 0; i < 2; i++) begin
      rmc_bc_model_inst.send(i ? 16'h2c11 : 16'hfbe2, 1'b0, -1, resp, irq);
      chk({12'h0, host_rdata[11], resp}, 16'h0000);
    end
    bcast_disable = 1'b0;
    global_busy   = 1'b0;
    wr(16'h0004);
    rmc_bc_model_inst.send(16'h2800, 1'b0, 1, resp, irq);
    pulse(1'b0);
    chk(host_rdata & 16'h0c00, 16'h0000);
    // first message after soft reset takes buffer a, then the pointer inverts
    rmc_bc_model_inst.send(16'h2800, 1'b0, 1, resp, irq);
    chk({13'h0, resp}, 16'h0000);
    chk({15'h0, host_rdata[10]}, 16'h0001);
    exec_active = 1'b0;
    wr(16'h0000);
    // pointer now set, yet indexed mode must take buffer a and leave the pointer alone
    rmc_bc_model_inst.send(16'h2812, 1'b0, 2, resp, irq);
    chk({14'h0, resp[1], host_rdata[10]}, 16'h0001);
    master_reset_pin = 1'b1;
    @(negedge sys_clk);
    master_reset_pin = 1'b0;
    chk(host_rdata, 16'h0000);
    print_verdict();
  end
endmodule : rt_rx_mode_ctrl_word_test
